// File: logic/asrs_pkg.sv
// constants, enumerations and carriers for the accumulator store, round and shift path
// assumes a single core clock; accumulators are owned and driven by the core
package asrs_pkg;

  localparam int ASRS_ACC_W = 40;
  localparam int ASRS_WORD_W = 16;
  localparam int ASRS_AMT_W = 6;
  localparam int ASRS_ADDR_W = 5;

  // register byte offsets on the Avalon slave
  localparam logic [4:0] ASRS_OFS_CTRL = 5'h00;
  localparam logic [4:0] ASRS_OFS_PTR = 5'h04;
  localparam logic [4:0] ASRS_OFS_LAST = 5'h08;
  localparam logic [4:0] ASRS_OFS_SHLO = 5'h0c;
  localparam logic [4:0] ASRS_OFS_SHHI = 5'h10;

  // core_control_reg field positions and reset values
  localparam int ASRS_CTRL_RND_BIT = 0;
  localparam int ASRS_CTRL_SAT_BIT = 1;
  localparam logic ASRS_RND_RESET = 1'b0;
  localparam logic ASRS_SAT_RESET = 1'b0;
  localparam logic [15:0] ASRS_PTR_RESET = 16'h0000;

  // datapath figures
  localparam logic [15:0] ASRS_HALF_LSB = 16'h8000;
  localparam logic [15:0] ASRS_MAX_POS = 16'h7fff;
  localparam logic [15:0] ASRS_MAX_NEG = 16'h8000;
  localparam logic [15:0] ASRS_PTR_STEP = 16'h0002;
  localparam logic [5:0] ASRS_SHIFT_MAX = 6'h10;
  localparam logic [8:0] ASRS_SAT_ALL0 = 9'h000;
  localparam logic [8:0] ASRS_SAT_ALL1 = 9'h1ff;

  typedef enum logic [2:0] {
    ASRS_OP_NOP = 3'h0,
    ASRS_OP_STORE_ACC = 3'h1,
    ASRS_OP_STORE_ACC_ROUND = 3'h2,
    ASRS_OP_MULTIPLY_ACCUM_CLASS = 3'h3,
    ASRS_OP_SHIFT_DSP = 3'h4,
    ASRS_OP_SHIFT_MCU = 3'h5
  } asrs_op_t;

  typedef enum logic [2:0] {
    ASRS_MAC_GENERIC = 3'h0,
    ASRS_MAC_PRODUCT_LOAD_OP = 3'h1,
    ASRS_MAC_NEGATIVE_PRODUCT_OP = 3'h2,
    ASRS_MAC_DIST_SQUARE_OP = 3'h3,
    ASRS_MAC_DIST_SQUARE_ACC_OP = 3'h4
  } asrs_mac_kind_t;

  typedef enum logic [1:0] {
    ASRS_WB_NONE = 2'h0,
    ASRS_WB_REG_DIRECT = 2'h1,
    ASRS_WB_INDIRECT_POSTINC = 2'h2
  } asrs_wb_mode_t;

  typedef struct packed {
    logic valid;
    asrs_op_t op;
    asrs_mac_kind_t mac_kind;
    asrs_wb_mode_t wb_mode;
    logic acc_sel;
    logic [15:0] addr;
    logic shift_src_x;
    logic shift_arith;
    logic [5:0] shift_amt;
    logic [15:0] xbus;
  } asrs_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
  } asrs_memwr_t;

endpackage

// File: logic/asrs_top.sv
// store path: round or truncate, store saturation, write-back and 40-bit barrel shifter
// assumes commands arrive synchronous to clk from the core and the accumulators are stable
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE1 - most multiply class ops store rounded other-accumulator word
// RULE2 - write-back goes over X bus to data space
// RULE3 - register direct mode loads pointer with value
// RULE4 - indirect mode stores at pointer, pointer plus two
// RULE5 - round select bit picks biased or convergent
// RULE6 - round logic is combinational, 16-bit result
// RULE7 - no rounding stores truncated high word
// RULE8 - low word 0x8000 upward increments high word
// RULE9 - exactly half rounds up only when bit16 set
// RULE10 - store ops write target high word, saturated
// RULE11 - multiply class write-back is always rounded
// RULE12 - saturation never alters source accumulator
// RULE13 - saturate to 0x7fff or 0x8000 when enabled
// RULE14 - bit 39 gives sign for saturation test
// RULE15 - saturation disabled passes data unmodified
// RULE16 - single-cycle shift up to sixteen, acc or X
// RULE17 - positive amount right, negative left, zero none
// RULE18 - 40-bit result for DSP, 16-bit for MCU
// RULE19 - X operand at 16..31 right, 0..15 left
// RULE20 - saturate enable switches store saturation independently
// RULE21 - non-target accumulator is the other one
module asrs_top
  import asrs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire asrs_pkg::asrs_cmd_t cmd,
  input wire logic [39:0] acc_a,
  input wire logic [39:0] acc_b,
  output asrs_pkg::asrs_memwr_t mem_wr,
  output logic [15:0] writeback_pointer_reg,
  output logic shift_valid,
  output logic [39:0] shift_dsp_result,
  output logic [15:0] shift_mcu_result
);
  import asrs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic round_select_bit_q;
  logic store_saturate_enable_q;
  logic [15:0] ptr_q;
  logic [15:0] last_store_q;
  logic wait_q;
  logic [31:0] rdata_q;
  asrs_memwr_t memwr_q;
  logic shv_q;
  logic [39:0] shdsp_q;
  logic [15:0] shmcu_q;

  logic bus_req;
  logic bus_wr_now;
  logic [31:0] rd_word;

  logic is_store;
  logic mac_wb;
  logic do_round;
  logic src_sel;
  logic [39:0] src_acc;
  logic [15:0] acc_high_word;
  logic [15:0] acc_low_word;
  logic round_inc;
  logic [23:0] ext_val;
  logic [15:0] store_val;
  logic is_shift;
  logic [39:0] sh_operand;
  logic [39:0] sh_result;
  logic [5:0] sh_mag;
  logic sh_left;

  ////////////////////////////////////////////////////////////////////////////
  // round and store saturation datapath

  always_comb
  begin
    is_store = cmd.valid &&
      (cmd.op == ASRS_OP_STORE_ACC || cmd.op == ASRS_OP_STORE_ACC_ROUND);
    // write-back only for the generic class, never the excluded forms
    mac_wb = cmd.valid && cmd.op == ASRS_OP_MULTIPLY_ACCUM_CLASS &&
      cmd.mac_kind == ASRS_MAC_GENERIC && cmd.wb_mode != ASRS_WB_NONE; // RULE1
    do_round = (cmd.op == ASRS_OP_STORE_ACC_ROUND) || mac_wb; // RULE11
    src_sel = mac_wb ? ~cmd.acc_sel : cmd.acc_sel; // RULE21
    src_acc = src_sel ? acc_b : acc_a; // RULE10
    acc_high_word = src_acc[31:16];
    acc_low_word = src_acc[15:0];
    round_inc = 1'b0;
    if (do_round)
    begin
      if (round_select_bit_q && acc_low_word == ASRS_HALF_LSB) // RULE5
        round_inc = src_acc[16]; // RULE9
      else
        round_inc = acc_low_word[15]; // RULE8
    end
    // without rounding the low word is simply dropped
    ext_val = src_acc[39:16] + {23'h000000, round_inc}; // RULE6 RULE7
    store_val = ext_val[15:0]; // RULE15
    if (store_saturate_enable_q) // RULE20
    begin
      if (!src_acc[39] && ext_val[23:15] != ASRS_SAT_ALL0) // RULE14
        store_val = ASRS_MAX_POS; // RULE13
      else if (src_acc[39] && ext_val[23:15] != ASRS_SAT_ALL1) // RULE14
        store_val = ASRS_MAX_NEG; // RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // barrel shifter

  always_comb
  begin
    is_shift = cmd.valid &&
      (cmd.op == ASRS_OP_SHIFT_DSP || cmd.op == ASRS_OP_SHIFT_MCU);
    sh_left = cmd.shift_amt[5]; // RULE17
    sh_mag = sh_left ? 6'(-cmd.shift_amt) : cmd.shift_amt;
    if (sh_mag > ASRS_SHIFT_MAX)
      sh_mag = ASRS_SHIFT_MAX; // RULE16
    if (cmd.op == ASRS_OP_SHIFT_MCU || cmd.shift_src_x) // RULE16
    begin
      if (sh_left)
        sh_operand = {24'h000000, cmd.xbus}; // RULE19
      else if (cmd.shift_arith)
        sh_operand = {{8{cmd.xbus[15]}}, cmd.xbus, 16'h0000}; // RULE19
      else
        sh_operand = {8'h00, cmd.xbus, 16'h0000}; // RULE19
    end
    else
    begin
      sh_operand = cmd.acc_sel ? acc_b : acc_a;
    end
    if (sh_left)
      sh_result = sh_operand << sh_mag; // RULE17
    else if (cmd.shift_arith)
      sh_result = 40'($signed(sh_operand) >>> sh_mag); // RULE16
    else
      sh_result = sh_operand >> sh_mag; // RULE16
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shv_q <= 1'b0;
      shdsp_q <= 40'h0000000000;
      shmcu_q <= 16'h0000;
    end
    else
    begin
      shv_q <= is_shift;
      if (is_shift)
      begin
        shdsp_q <= sh_result; // RULE18
        // right shifts read the word lane, left shifts the low lane
        shmcu_q <= sh_left ? sh_result[15:0] : sh_result[31:16]; // RULE18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data space write and write-back pointer

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      memwr_q <= '0;
      last_store_q <= 16'h0000;
    end
    else
    begin
      memwr_q.valid <= 1'b0;
      if (is_store)
      begin
        memwr_q.valid <= 1'b1; // RULE2 RULE10
        memwr_q.addr <= cmd.addr;
        memwr_q.data <= store_val;
        last_store_q <= store_val;
      end
      else if (mac_wb)
      begin
        if (cmd.wb_mode == ASRS_WB_INDIRECT_POSTINC)
        begin
          memwr_q.valid <= 1'b1; // RULE2 RULE4
          memwr_q.addr <= ptr_q; // RULE4
          memwr_q.data <= store_val;
        end
        last_store_q <= store_val;
      end
    end
  end

  // the core's write-back wins over a bus write in the same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ptr_q <= ASRS_PTR_RESET;
    else if (mac_wb && cmd.wb_mode == ASRS_WB_REG_DIRECT)
      ptr_q <= store_val; // RULE3
    else if (mac_wb && cmd.wb_mode == ASRS_WB_INDIRECT_POSTINC)
      ptr_q <= ptr_q + ASRS_PTR_STEP; // RULE4
    else if (bus_wr_now && avs_address == ASRS_OFS_PTR)
    begin
      if (avs_byteenable[0])
        ptr_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        ptr_q[15:8] <= avs_writedata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave

  assign bus_req = avs_read || avs_write;
  assign bus_wr_now = avs_write && !wait_q;

  always_comb
  begin
    rd_word = 32'h00000000;
    case (avs_address)
      ASRS_OFS_CTRL:
      begin
        rd_word[ASRS_CTRL_RND_BIT] = round_select_bit_q;
        rd_word[ASRS_CTRL_SAT_BIT] = store_saturate_enable_q;
      end
      ASRS_OFS_PTR: rd_word[15:0] = ptr_q;
      ASRS_OFS_LAST: rd_word[15:0] = last_store_q;
      ASRS_OFS_SHLO: rd_word = shdsp_q[31:0];
      ASRS_OFS_SHHI: rd_word[7:0] = shdsp_q[39:32];
      default: rd_word = 32'h00000000;
    endcase
  end

  // one wait cycle per access; the request completes on the low edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else if (bus_req && wait_q)
    begin
      wait_q <= 1'b0;
      rdata_q <= avs_read ? rd_word : 32'h00000000;
    end
    else
    begin
      wait_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      round_select_bit_q <= ASRS_RND_RESET;
      store_saturate_enable_q <= ASRS_SAT_RESET;
    end
    else if (bus_wr_now && avs_address == ASRS_OFS_CTRL && avs_byteenable[0])
    begin
      round_select_bit_q <= avs_writedata[ASRS_CTRL_RND_BIT]; // RULE5
      store_saturate_enable_q <= avs_writedata[ASRS_CTRL_SAT_BIT]; // RULE20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the accumulators are only read here, never written back

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign mem_wr = memwr_q; // RULE12
  assign writeback_pointer_reg = ptr_q;
  assign shift_valid = shv_q;
  assign shift_dsp_result = shdsp_q;
  assign shift_mcu_result = shmcu_q;

endmodule

`default_nettype wire

// File: verification/asrs_mem_model.sv
// data memory write path behind the store path, word wide
// assumes word writes at even byte addresses; counts odd ones
`timescale 1ns/1ps
`default_nettype none
module asrs_mem_model
  import asrs_pkg::*;
(
  input wire logic clk,
  input wire asrs_pkg::asrs_memwr_t wr
);
  import asrs_pkg::*;
  logic [15:0] mem [0:255];
  int n_bad = 0;
  always_ff @(posedge clk)
  begin
    if (wr.valid)
    begin
      mem[wr.addr[8:1]] <= wr.data;
      if (wr.addr[0])
        n_bad <= n_bad + 1;
    end
  end
endmodule
`default_nettype wire

// File: verification/asrs_monitor.sv
// checker for the store, write-back and shift paths of asrs_top
// assumes the one clock and the async low reset of the top module
`timescale 1ns/1ps
`default_nettype none
module asrs_monitor
  import asrs_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire asrs_pkg::asrs_cmd_t cmd,
  input wire logic [39:0] acc_a,
  input wire logic [39:0] acc_b,
  input wire asrs_pkg::asrs_memwr_t mem_wr,
  input wire logic [15:0] writeback_pointer_reg,
  input wire logic shift_valid,
  input wire logic [39:0] shift_dsp_result,
  input wire logic [15:0] shift_mcu_result
);
  import asrs_pkg::*;
  wire logic st = cmd.valid && cmd.op == ASRS_OP_STORE_ACC;
  wire logic mac = cmd.valid && cmd.op == ASRS_OP_MULTIPLY_ACCUM_CLASS;
  wire logic mac_g = mac && cmd.mac_kind == ASRS_MAC_GENERIC;
  wire logic dsp = cmd.valid && cmd.op == ASRS_OP_SHIFT_DSP;
  wire logic mcu = cmd.valid && cmd.op == ASRS_OP_SHIFT_MCU;
  wire logic [39:0] tgt = cmd.acc_sel ? acc_b : acc_a;
  wire logic [39:0] oth = cmd.acc_sel ? acc_a : acc_b;
  logic [39:0] tgt_q;
  logic [39:0] oth_q;
  logic [15:0] ptr_q;
  logic [15:0] adr_q;
  logic [15:0] xb_q;
  always_ff @(posedge clk)
  begin
    tgt_q <= tgt;
    oth_q <= oth;
    ptr_q <= writeback_pointer_reg;
    adr_q <= cmd.addr;
    xb_q <= cmd.xbus;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_bus_ack_once: assert property (s_req |=> s_ack)
    else $error("bus ack not a single cycle");
  a_trunc_store: assert property (st && tgt[39:31] == 9'h000 |=> mem_wr.valid
    && mem_wr.data == tgt_q[31:16] && mem_wr.addr == adr_q)
    else $error("truncated store wrong");
  a_wb_postinc: assert property (mac_g && cmd.wb_mode == ASRS_WB_INDIRECT_POSTINC
    |=> mem_wr.valid && mem_wr.addr == ptr_q && writeback_pointer_reg == ptr_q + 16'h0002)
    else $error("indirect write-back wrong");
  a_wb_direct: assert property (mac_g && cmd.wb_mode == ASRS_WB_REG_DIRECT
    && oth[39:30] == 10'h000 && oth[15:0] != 16'h8000
    |=> !mem_wr.valid && writeback_pointer_reg == oth_q[31:16] + 16'(oth_q[15]))
    else $error("direct write-back wrong");
  a_no_wb_kind: assert property (mac && cmd.mac_kind != ASRS_MAC_GENERIC
    && !(avs_write && !avs_waitrequest) |=> !mem_wr.valid && $stable(writeback_pointer_reg))
    else $error("excluded op wrote back");
  a_shift_pulse: assert property (shift_valid == $past(dsp || mcu))
    else $error("shift valid not one cycle after op");
  a_zero_shift: assert property (dsp && !cmd.shift_src_x && cmd.shift_amt == 6'h00
    |=> shift_dsp_result == tgt_q)
    else $error("zero shift changed operand");
  a_x_right16: assert property (dsp && cmd.shift_src_x && !cmd.shift_arith
    && cmd.shift_amt == 6'h10 |=> shift_dsp_result == {24'h000000, xb_q})
    else $error("x bus right shift wrong");
  a_mcu_left1: assert property (mcu && cmd.shift_amt == 6'h3f
    |=> shift_mcu_result == {xb_q[14:0], 1'b0})
    else $error("mcu left shift wrong");
endmodule
bind asrs_top asrs_monitor u_mon (.clk(clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .cmd(cmd), .acc_a(acc_a),
  .acc_b(acc_b), .mem_wr(mem_wr), .writeback_pointer_reg(writeback_pointer_reg),
  .shift_valid(shift_valid), .shift_dsp_result(shift_dsp_result),
  .shift_mcu_result(shift_mcu_result));
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for asrs_top: registers, rounding, saturation, write-back, shifts
// assumes the memory model on mem_wr and the checker bound to the top module
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asrs_pkg::*;
  logic clk = 0;
  logic resetn = 0;
  logic [4:0] avs_address = '0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  asrs_cmd_t cmd = '0;
  logic [39:0] acc_a = '0;
  logic [39:0] acc_b = '0;
  asrs_memwr_t mem_wr;
  logic [15:0] ptr;
  logic shift_valid;
  logic [39:0] dsp;
  logic [15:0] mcu;
  logic [31:0] q;
  int n_errors = 0;
  int cmp_count = 0;
  asrs_top uut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd(cmd),
    .acc_a(acc_a), .acc_b(acc_b), .mem_wr(mem_wr), .writeback_pointer_reg(ptr),
    .shift_valid(shift_valid), .shift_dsp_result(dsp), .shift_mcu_result(mcu));
  asrs_mem_model u_mem (.clk(clk), .wr(mem_wr));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    for (i = 0; i < 20 && avs_waitrequest !== 1'b0; i++)
      @(posedge clk);
    if (i == 20)
    begin
      n_errors++;
      give_verdict();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task run(input asrs_op_t op, input asrs_mac_kind_t k, input asrs_wb_mode_t w, input logic s,
    input logic [5:0] amt, input logic x, input logic [39:0] a, input logic [39:0] b);
    @(posedge clk);
    cmd <= '{1'b1, op, k, w, s, 16'h0040, x, !x, amt, 16'h9234};
    acc_a <= a;
    acc_b <= b;
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
  endtask
  function automatic logic [15:0] ref_st(logic [39:0] a, logic rnd, logic conv, logic sat);
    logic [23:0] e;
    e = a[39:16] + 24'(rnd & ((conv && a[15:0] == 16'h8000) ? a[16] : a[15]));
    if (sat && !a[39] && e[23:15] != 9'h000)
      return 16'h7fff;
    if (sat && a[39] && e[23:15] != 9'h1ff)
      return 16'h8000;
    return e[15:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task s_regs();
    bus(1'b0, ASRS_OFS_CTRL, 32'h0);
    chk(40'(q), 40'h0);
    bus(1'b0, ASRS_OFS_PTR, 32'h0);
    chk(40'(q), 40'h0);
    bus(1'b1, 5'h14, 32'hffff);
    bus(1'b0, 5'h14, 32'h0);
    chk(40'(q), 40'h0);
  endtask
  task s_store();
    logic [39:0] av [7];
    av = '{40'h0012348000, 40'h0012358000, 40'h001234ffff, 40'h0012347fff,
      40'h0123450000, 40'hff7fff0000, 40'h007fff8000};
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, ASRS_OFS_CTRL, 32'(m));
      for (int i = 0; i < 14; i++)
      begin
        run(i[0] ? ASRS_OP_STORE_ACC_ROUND : ASRS_OP_STORE_ACC, ASRS_MAC_GENERIC,
          ASRS_WB_NONE, 1'b1, 6'h00, 1'b0, 40'h0, av[i / 2]);
        chk(40'(mem_wr.valid), 40'h1);
        chk(40'(mem_wr.data), 40'(ref_st(av[i / 2], i[0], m[0], m[1])));
      end
    end
  endtask
  task s_wb();
    bus(1'b1, ASRS_OFS_CTRL, 32'h2);
    bus(1'b1, ASRS_OFS_PTR, 32'h0100);
    bus(1'b0, ASRS_OFS_PTR, 32'h0);
    chk(40'(q), 40'h0100);
    bus(1'b0, ASRS_OFS_CTRL, 32'h0);
    chk(40'(q), 40'h2);
    run(ASRS_OP_MULTIPLY_ACCUM_CLASS, ASRS_MAC_GENERIC, ASRS_WB_INDIRECT_POSTINC, 1'b0,
      6'h00, 1'b0, 40'h0, 40'h0012348000);
    chk(40'(ptr), 40'h0102);
    #5;
    chk(40'(u_mem.mem[8'h80]), 40'h1235);
    bus(1'b0, ASRS_OFS_LAST, 32'h0);
    chk(40'(q), 40'h1235);
    run(ASRS_OP_MULTIPLY_ACCUM_CLASS, ASRS_MAC_GENERIC, ASRS_WB_REG_DIRECT, 1'b1,
      6'h00, 1'b0, 40'h0000568000, 40'h0);
    chk(40'(ptr), 40'h0057);
    for (int k = 1; k < 5; k++)
    begin
      run(ASRS_OP_MULTIPLY_ACCUM_CLASS, asrs_mac_kind_t'(k), ASRS_WB_INDIRECT_POSTINC, 1'b0,
        6'h00, 1'b0, 40'h0, 40'h0012348000);
      chk(40'({mem_wr.valid, ptr}), 40'h0057);
    end
    // convergent mode, other accumulator above half and at exactly half
    bus(1'b1, ASRS_OFS_CTRL, 32'h1);
    run(ASRS_OP_MULTIPLY_ACCUM_CLASS, ASRS_MAC_GENERIC, ASRS_WB_REG_DIRECT, 1'b0,
      6'h00, 1'b0, 40'h0, 40'h000012c000);
    chk(40'({mem_wr.valid, ptr}), 40'h0013);
    run(ASRS_OP_MULTIPLY_ACCUM_CLASS, ASRS_MAC_GENERIC, ASRS_WB_REG_DIRECT, 1'b0,
      6'h00, 1'b0, 40'h0, 40'h0000128000);
    chk(40'(ptr), 40'h0012);
    chk(40'(u_mem.n_bad), 40'h0);
  endtask
  task s_shift();
    run(ASRS_OP_SHIFT_DSP, ASRS_MAC_GENERIC, ASRS_WB_NONE, 1'b0, 6'h10, 1'b0, 40'h8000000000, 0);
    chk(dsp, 40'hffff800000);
    bus(1'b0, ASRS_OFS_SHLO, 32'h0);
    chk(40'(q), 40'hff800000);
    bus(1'b0, ASRS_OFS_SHHI, 32'h0);
    chk(40'(q), 40'hff);
    run(ASRS_OP_SHIFT_DSP, ASRS_MAC_GENERIC, ASRS_WB_NONE, 1'b1, 6'h30, 1'b0, 0, 40'h1234);
    chk(dsp, 40'h0012340000);
    run(ASRS_OP_SHIFT_DSP, ASRS_MAC_GENERIC, ASRS_WB_NONE, 1'b1, 6'h00, 1'b0, 0, 40'h5a5a);
    chk(dsp, 40'h5a5a);
    run(ASRS_OP_SHIFT_DSP, ASRS_MAC_GENERIC, ASRS_WB_NONE, 1'b0, 6'h10, 1'b1, 0, 0);
    chk(dsp, 40'h9234);
    run(ASRS_OP_SHIFT_DSP, ASRS_MAC_GENERIC, ASRS_WB_NONE, 1'b0, 6'h3c, 1'b1, 0, 0);
    chk(dsp, 40'h92340);
    run(ASRS_OP_SHIFT_MCU, ASRS_MAC_GENERIC, ASRS_WB_NONE, 1'b0, 6'h3f, 1'b1, 0, 0);
    chk(40'(mcu), 40'h2468);
    run(ASRS_OP_SHIFT_MCU, ASRS_MAC_GENERIC, ASRS_WB_NONE, 1'b0, 6'h04, 1'b1, 0, 0);
    chk(40'({shift_valid, mcu}), 40'h10923);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    s_regs();
    s_store();
    s_wb();
    s_shift();
    give_verdict();
  end
endmodule
`default_nettype wire
